// File: shared/cbo_pkg.sv
package cbo_pkg;

  // ******************************
  // block geometry
  // ******************************
  localparam int unsigned BLK_BITS    = 272;
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned BUF_WORDS   = 17;
  localparam int unsigned ADDR_W      = 5;
  localparam int unsigned IDX_W       = 9;
  localparam int unsigned VNUM_W      = 8;
  localparam logic [8:0]  FRAME_BLKS  = 9'h110;
  localparam logic [8:0]  VSLOT_FIRST = 9'h01D;
  localparam logic [8:0]  VSLOT_LAST  = 9'h0DA;
  localparam logic [7:0]  VBLKS       = 8'hBE;
  localparam logic [8:0]  VSLOT_BASE  = 9'h01C;
  localparam logic [4:0]  LAST_WORD   = 5'h10;

  // ******************************
  // timing
  // ******************************
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned T_READ_US    = 8000;
  localparam int unsigned T_HONLY_US   = 17000;
  localparam int unsigned T_MARGIN_US  = 3000;
  localparam int unsigned READ_CYC     = T_READ_US * CLK_MHZ;
  localparam int unsigned HONLY_CYC    = T_HONLY_US * CLK_MHZ;
  localparam int unsigned MARGIN_CYC   = T_MARGIN_US * CLK_MHZ;
  localparam int unsigned TMR_W        = 21;

  // ******************************
  // reset values
  // ******************************
  localparam logic [8:0]  IDX_RST  = 9'h000;
  localparam logic [15:0] WORD_RST = 16'h0000;

  typedef enum logic [1:0] {
    REQ_IDLE,
    REQ_GAP,
    REQ_LOW
  } cbo_req_t;

  function automatic logic cbo_in_vrange(input logic [8:0] idx);
    return (idx >= VSLOT_FIRST) && (idx <= VSLOT_LAST);
  endfunction

endpackage

// File: verilog/cbo_sel.sv
`timescale 1ns/10ps
`default_nettype none

module cbo_sel (
  input  wire logic                       output_all_in,
  input  wire logic                       vforce_in,
  input  wire logic [cbo_pkg::IDX_W-1:0]  blk_idx_in,
  input  wire logic [cbo_pkg::IDX_W-1:0]  blk_idx_nxt_in,
  input  wire logic                       h_crc_ok_in,
  input  wire logic                       blk_sync_in,
  input  wire logic                       frm_sync_in,
  input  wire logic                       data_pkt_in,
  input  wire logic                       vran_in,
  input  wire logic                       prev_fail_in,
  input  wire logic                       vrsp_hfail_in,
  input  wire logic                       vrsp_vok_in,
  output logic                            h_offer_out,
  output logic                            v_offer_out,
  output logic                            vslot_hit_out,
  output logic [cbo_pkg::VNUM_W-1:0]      vslot_num_out,
  output logic                            honly_out
);
  import cbo_pkg::*;

  // ******************************
  // horizontal gate
  // ******************************
  wire h_default = h_crc_ok_in && blk_sync_in && frm_sync_in && data_pkt_in;
  assign h_offer_out = output_all_in || h_default;

  // ******************************
  // vertical gate
  // ******************************
  // hok blocks never reach default output: the vertical pass left them untouched
  wire v_default = vran_in && vrsp_hfail_in && vrsp_vok_in;
  wire v_all     = output_all_in && vforce_in;
  wire v_onfail  = output_all_in && !vforce_in && prev_fail_in;
  wire v_good    = !output_all_in && vforce_in && vrsp_vok_in;
  assign v_offer_out = v_all || v_onfail || v_good ||
                       (!output_all_in && !vforce_in && v_default);

  // ******************************
  // slot positions
  // ******************************
  wire [IDX_W-1:0] slot_off = blk_idx_nxt_in - VSLOT_BASE;
  assign vslot_hit_out = cbo_in_vrange(blk_idx_nxt_in);
  assign vslot_num_out = slot_off[VNUM_W-1:0];
  assign honly_out     = !cbo_in_vrange(blk_idx_in);

endmodule

`default_nettype wire

// File: verilog/cbo_win.sv
`timescale 1ns/10ps
`default_nettype none

module cbo_win #(
  parameter int unsigned READ_CYC   = cbo_pkg::READ_CYC,
  parameter int unsigned HONLY_CYC  = cbo_pkg::HONLY_CYC,
  parameter int unsigned MARGIN_CYC = cbo_pkg::MARGIN_CYC
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  input  wire logic start_in,
  input  wire logic long_in,
  input  wire logic stop_in,
  output logic      expire_out,
  output logic      release_out
);
  import cbo_pkg::*;

  localparam logic [TMR_W-1:0] SHORT_LEN = TMR_W'(READ_CYC);
  localparam logic [TMR_W-1:0] LONG_LEN  = TMR_W'(HONLY_CYC);
  localparam logic [TMR_W-1:0] MARGIN    = TMR_W'(MARGIN_CYC);
  localparam logic [TMR_W-1:0] ONE       = TMR_W'(1);

  logic [TMR_W-1:0] cnt_r;
  logic [TMR_W-1:0] cnt_nxt;

  // ******************************
  // read window countdown
  // ******************************
  wire running = (cnt_r != '0);
  assign expire_out  = running && (cnt_r == ONE);
  assign release_out = running && (cnt_r == MARGIN);
  assign cnt_nxt = start_in ? (long_in ? LONG_LEN : SHORT_LEN) :
                   stop_in  ? '0 :
                   running  ? cnt_r - ONE : cnt_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r <= '0;
    end else if (ce_in) begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

`default_nettype wire

// File: verilog/cbo_ctrl.sv
// How it works
// - check, correct each block, then stage it
// - default horizontal offer needs four conditions
// - frame product pass when horizontal failures remain
// - default vertical: hfail, vfixed data blocks only
// - skip vertical on clean frame or sync loss
// - one-block buffer, newest block overwrites
// - window expiry releases buffer for next block
// - request low per ready block, one block
// - packet N offered during packet N+1
// - vertical pass of previous frame at head
// - 190 vertical slots, blocks 29 to 218
// - suppressed vertical slot still consumed, no request
// - output-all and vertical force select modes
// - output-all offers every horizontal block
// - both bits: all 190 vertical blocks
// - output-all only: vertical on failed frame
// - force only: good vertical blocks always
// - frame fails if any block failed
// - flag falls with request, rises 3 ms early
// - flag mode off: pin driven only during output
`timescale 1ns/10ps
`default_nettype none

module cbo_ctrl #(
  parameter int unsigned READ_CYC   = cbo_pkg::READ_CYC,
  parameter int unsigned HONLY_CYC  = cbo_pkg::HONLY_CYC,
  parameter int unsigned MARGIN_CYC = cbo_pkg::MARGIN_CYC
) (
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  input  wire logic                          ce_in,
  input  wire logic                          output_all_in,
  input  wire logic                          flag_mode_in,
  input  wire logic                          vertical_output_force_in,
  input  wire logic                          frame_start_in,
  input  wire logic                          block_id_code_in,
  input  wire logic                          h_done_in,
  input  wire logic [cbo_pkg::BLK_BITS-1:0]  h_data_in,
  input  wire logic                          h_crc_ok_in,
  input  wire logic                          blk_sync_in,
  input  wire logic                          frm_sync_in,
  input  wire logic                          data_pkt_in,
  output logic                               vcorr_start_out,
  input  wire logic                          vcorr_done_in,
  output logic                               vfetch_out,
  output logic [cbo_pkg::VNUM_W-1:0]         vfetch_num_out,
  input  wire logic                          vrsp_valid_in,
  input  wire logic [cbo_pkg::BLK_BITS-1:0]  vrsp_data_in,
  input  wire logic                          vrsp_hfail_in,
  input  wire logic                          vrsp_vok_in,
  input  wire logic                          rd_strobe_in,
  input  wire logic [cbo_pkg::ADDR_W-1:0]    rd_addr_in,
  output logic [cbo_pkg::WORD_W-1:0]         rd_data_out,
  output logic                               xfer_req_n_out,
  output logic                               win_flag_out,
  output logic                               win_flag_oe_out
);
  import cbo_pkg::*;

  // ******************************
  // state
  // ******************************
  logic [WORD_W-1:0]  buf_r [BUF_WORDS];
  logic [IDX_W-1:0]   blk_idx_r;
  logic [IDX_W-1:0]   blk_idx_nxt;
  cbo_req_t           req_r;
  cbo_req_t           req_nxt;
  logic               frame_fail_r;
  logic               frame_sync_ok_r;
  logic               prev_fail_r;
  logic               vrun_r;
  logic               vran_r;
  logic               vpend_r;
  logic               vwait_r;
  logic               honly_r;
  logic [1:0]         stb_sync_r;
  logic               stb_d_r;
  logic [ADDR_W-1:0]  addr_s1_r;
  logic [ADDR_W-1:0]  addr_s2_r;
  logic               rd_busy_r;

  wire h_offer;
  wire v_offer;
  wire vslot_hit;
  wire [VNUM_W-1:0] vslot_num;
  wire honly;
  wire win_expire;
  wire win_release;

  cbo_sel u_sel (
    .output_all_in  (output_all_in),
    .vforce_in      (vertical_output_force_in),
    .blk_idx_in     (blk_idx_r),
    .blk_idx_nxt_in (blk_idx_nxt),
    .h_crc_ok_in    (h_crc_ok_in),
    .blk_sync_in    (blk_sync_in),
    .frm_sync_in    (frm_sync_in),
    .data_pkt_in    (data_pkt_in),
    .vran_in        (vran_r),
    .prev_fail_in   (prev_fail_r),
    .vrsp_hfail_in  (vrsp_hfail_in),
    .vrsp_vok_in    (vrsp_vok_in),
    .h_offer_out    (h_offer),
    .v_offer_out    (v_offer),
    .vslot_hit_out  (vslot_hit),
    .vslot_num_out  (vslot_num),
    .honly_out      (honly)
  );

  // ******************************
  // block and frame tracking
  // ******************************
  wire blk_tick = block_id_code_in && (blk_idx_r != FRAME_BLKS);
  assign blk_idx_nxt = frame_start_in ? IDX_W'(1) :
                       blk_tick       ? blk_idx_r + IDX_W'(1) : blk_idx_r;
  wire h_fail    = h_done_in && !h_crc_ok_in;
  wire fail_now  = frame_fail_r || h_fail;
  wire sync_now  = frame_sync_ok_r && frm_sync_in;
  // clean frame or sync loss: vertical pass is skipped entirely
  wire vneed     = frame_start_in && fail_now && sync_now;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      blk_idx_r       <= IDX_RST;
      frame_fail_r    <= 1'b0;
      frame_sync_ok_r <= 1'b1;
      prev_fail_r     <= 1'b0;
      vcorr_start_out <= 1'b0;
      vrun_r          <= 1'b0;
      vran_r          <= 1'b0;
    end else if (ce_in) begin
      blk_idx_r       <= blk_idx_nxt;
      frame_fail_r    <= frame_start_in ? 1'b0 : fail_now;
      frame_sync_ok_r <= frame_start_in ? 1'b1 : sync_now;
      prev_fail_r     <= frame_start_in ? fail_now : prev_fail_r;
      vcorr_start_out <= vneed;
      vrun_r          <= frame_start_in ? vneed : (vrun_r && !vcorr_done_in);
      vran_r          <= frame_start_in ? 1'b0 : (vran_r || (vrun_r && vcorr_done_in));
    end
  end

  // ******************************
  // vertical slot fetch
  // ******************************
  // a fetch waits for the horizontal window so the two share the block time
  wire req_busy  = (req_r != REQ_IDLE);
  wire vfetch    = vpend_r && !req_busy && !vwait_r;
  wire vload     = vrsp_valid_in && v_offer;
  wire hload     = h_done_in && h_offer;
  wire load_any  = hload || vload;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      vpend_r        <= 1'b0;
      vwait_r        <= 1'b0;
      vfetch_out     <= 1'b0;
      vfetch_num_out <= '0;
    end else if (ce_in) begin
      vpend_r    <= (blk_tick && vslot_hit) || (vpend_r && !vfetch);
      vwait_r    <= vfetch || (vwait_r && !vrsp_valid_in);
      vfetch_out <= vfetch;
      if (blk_tick && vslot_hit) begin
        vfetch_num_out <= vslot_num;
      end
    end
  end

  // ******************************
  // output buffer
  // ******************************
  always_ff @(posedge clk_in) begin
    if (ce_in && load_any) begin
      for (int i = 0; i < BUF_WORDS; i++) begin
        buf_r[i] <= hload ? h_data_in[i*WORD_W +: WORD_W]
                          : vrsp_data_in[i*WORD_W +: WORD_W];
      end
    end
  end

  // ******************************
  // host read port
  // ******************************
  wire rd_edge = stb_sync_r[1] && !stb_d_r;
  wire rd_done = rd_edge && (addr_s2_r == LAST_WORD);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stb_sync_r  <= 2'b00;
      stb_d_r     <= 1'b0;
      addr_s1_r   <= '0;
      addr_s2_r   <= '0;
      rd_data_out <= WORD_RST;
      rd_busy_r   <= 1'b0;
    end else if (ce_in) begin
      stb_sync_r  <= {stb_sync_r[0], rd_strobe_in};
      stb_d_r     <= stb_sync_r[1];
      addr_s1_r   <= rd_addr_in;
      addr_s2_r   <= addr_s1_r;
      if (rd_edge) begin
        rd_data_out <= (addr_s2_r <= LAST_WORD) ? buf_r[addr_s2_r] : WORD_RST;
      end
      rd_busy_r   <= (rd_edge && !rd_done) || (rd_busy_r && !rd_done && !load_any);
    end
  end

  // ******************************
  // transfer request
  // ******************************
  cbo_win #(
    .READ_CYC   (READ_CYC),
    .HONLY_CYC  (HONLY_CYC),
    .MARGIN_CYC (MARGIN_CYC)
  ) u_win (
    .clk_in      (clk_in),
    .rst_in      (rst_in),
    .ce_in       (ce_in),
    .start_in    (req_r == REQ_GAP && !load_any),
    .long_in     (honly_r),
    .stop_in     (rd_done || load_any),
    .expire_out  (win_expire),
    .release_out (win_release)
  );

  always_comb begin
    req_nxt = req_r;
    case (req_r)
      REQ_IDLE: req_nxt = load_any ? REQ_GAP : REQ_IDLE;
      REQ_GAP:  req_nxt = load_any ? REQ_GAP : REQ_LOW;
      REQ_LOW: begin
        if (load_any) begin
          req_nxt = REQ_GAP;
        end else if (win_expire || rd_done) begin
          req_nxt = REQ_IDLE;
        end
      end
      default: req_nxt = REQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      req_r          <= REQ_IDLE;
      xfer_req_n_out <= 1'b1;
      honly_r        <= 1'b1;
    end else if (ce_in) begin
      req_r          <= req_nxt;
      xfer_req_n_out <= (req_nxt != REQ_LOW);
      if (load_any) begin
        honly_r <= honly && !vpend_r && !vwait_r;
      end
    end
  end

  // ******************************
  // read window flag pin
  // ******************************
  wire req_fall = (req_r == REQ_GAP) && (req_nxt == REQ_LOW);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      win_flag_out    <= 1'b1;
      win_flag_oe_out <= 1'b0;
    end else if (ce_in) begin
      if (flag_mode_in) begin
        win_flag_oe_out <= 1'b1;
        win_flag_out    <= req_fall ? 1'b0 :
                           (rd_done || win_release || req_nxt != REQ_LOW) ? 1'b1 :
                           win_flag_out;
      end else begin
        // pin only driven while a read is under way, low marks output in progress
        win_flag_oe_out <= rd_busy_r || rd_edge;
        win_flag_out    <= 1'b0;
      end
    end
  end

  // ******************************
  // checks
  // ******************************
  property p_hreq;
    @(posedge clk_in) disable iff (rst_in)
    (hload && ce_in) ##1 (ce_in && !load_any) |=> !xfer_req_n_out;
  endproperty
  a_hreq: assert property (p_hreq) else $error("offered block gave no request");

  property p_gap;
    @(posedge clk_in) disable iff (rst_in)
    (load_any && ce_in && req_r == REQ_LOW) |=> xfer_req_n_out;
  endproperty
  a_gap: assert property (p_gap) else $error("request not raised between blocks");

  property p_nosup;
    @(posedge clk_in) disable iff (rst_in)
    (ce_in && !load_any && req_r == REQ_IDLE) |=> xfer_req_n_out;
  endproperty
  a_nosup: assert property (p_nosup) else $error("request without offered block");

  property p_vnum;
    @(posedge clk_in) disable iff (rst_in)
    vfetch_out |-> (vfetch_num_out >= 8'h01) && (vfetch_num_out <= VBLKS);
  endproperty
  a_vnum: assert property (p_vnum) else $error("vertical slot out of range");

  property p_vstart;
    @(posedge clk_in) disable iff (rst_in)
    vcorr_start_out |-> $past(frame_start_in) && $past(fail_now);
  endproperty
  a_vstart: assert property (p_vstart) else $error("vertical pass without cause");

  property p_flag_fall;
    @(posedge clk_in) disable iff (rst_in)
    (flag_mode_in && $fell(xfer_req_n_out)) |-> !win_flag_out && win_flag_oe_out;
  endproperty
  a_flag_fall: assert property (p_flag_fall) else $error("flag did not fall with request");

  property p_flag_z;
    @(posedge clk_in) disable iff (rst_in)
    (ce_in && !flag_mode_in && !rd_busy_r && !rd_edge) |=> !win_flag_oe_out;
  endproperty
  a_flag_z: assert property (p_flag_z) else $error("flag pin driven while idle");

  property p_expire;
    @(posedge clk_in) disable iff (rst_in)
    (ce_in && req_r == REQ_LOW && win_expire && !load_any) |=> xfer_req_n_out;
  endproperty
  a_expire: assert property (p_expire) else $error("request outlived read window");

  property p_idx;
    @(posedge clk_in) disable iff (rst_in)
    blk_idx_r <= FRAME_BLKS;
  endproperty
  a_idx: assert property (p_idx) else $error("block index overran frame");

  c_hreq:   cover property (@(posedge clk_in) disable iff (rst_in) hload ##2 !xfer_req_n_out);
  c_vreq:   cover property (@(posedge clk_in) disable iff (rst_in) vload);
  c_expire: cover property (@(posedge clk_in) disable iff (rst_in) win_expire);
  c_rddone: cover property (@(posedge clk_in) disable iff (rst_in) rd_done);

endmodule

`default_nettype wire

// File: verif/cbo_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ************************************
// host reader: drains one block per request
// ************************************
module cbo_host_model (
  input  wire logic         clk_in,
  input  wire logic         en_in,
  input  wire logic [3:0]   slow_in,
  input  wire logic         xfer_req_n_in,
  input  wire logic [15:0]  rd_data_in,
  output logic              rd_strobe_out,
  output logic [4:0]        rd_addr_out,
  output logic [271:0]      blk_out,
  output logic [7:0]        cnt_out
);
  import cbo_pkg::*;

  initial begin
    rd_strobe_out = 1'b0;
    rd_addr_out = 5'h1F;
    blk_out = '0;
    cnt_out = 8'h00;
    forever begin
      @(posedge clk_in);
      #1;
      // reads only inside a request, well within the window
      if (en_in && xfer_req_n_in === 1'b0) begin
        repeat (slow_in) @(posedge clk_in);
        for (int w = 0; w < BUF_WORDS; w++) begin
          #1 rd_addr_out = w[4:0];
          @(posedge clk_in);
          #1 rd_strobe_out = 1'b1;
          repeat (5) @(posedge clk_in);
          #1;
          blk_out[w*16 +: 16] = rd_data_in;
          rd_strobe_out = 1'b0;
          repeat (2) @(posedge clk_in);
          // address no longer meaningful: show a changing pattern
          #1 rd_addr_out = ~w[4:0];
        end
        cnt_out = cnt_out + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  import cbo_pkg::*;

  localparam int unsigned RD_C = 400;
  localparam int unsigned HO_C = 800;
  localparam int unsigned MG_C = 100;

  logic         clk_in, rst_in, oa, fmode, vf, fs, block_id_code, hd, crc, bs, fsy, dp;
  logic         vdone, vvalid, vhf, vok, hen, strobe, vstart, vfetch, req_n, flag, flag_oe;
  logic [271:0] hdata, vdata, last_x, got;
  logic [4:0]   addr;
  logic [7:0]   hcnt, vnum;
  logic [15:0]  rdata;
  logic [3:0]   slow, st;
  logic         seen;
  int           err_count = 0;
  int           compares = 0;
  int           cyc = 0;
  int           r, f;

  cbo_ctrl #(.READ_CYC(RD_C), .HONLY_CYC(HO_C), .MARGIN_CYC(MG_C)) cbo_ctrl_inst (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .output_all_in(oa),
    .flag_mode_in(fmode), .vertical_output_force_in(vf), .frame_start_in(fs),
    .block_id_code_in(block_id_code), .h_done_in(hd), .h_data_in(hdata), .h_crc_ok_in(crc),
    .blk_sync_in(bs), .frm_sync_in(fsy), .data_pkt_in(dp), .vcorr_start_out(vstart),
    .vcorr_done_in(vdone), .vfetch_out(vfetch), .vfetch_num_out(vnum),
    .vrsp_valid_in(vvalid), .vrsp_data_in(vdata), .vrsp_hfail_in(vhf), .vrsp_vok_in(vok),
    .rd_strobe_in(strobe), .rd_addr_in(addr), .rd_data_out(rdata),
    .xfer_req_n_out(req_n), .win_flag_out(flag), .win_flag_oe_out(flag_oe));

  cbo_host_model cbo_host_model_inst (
    .clk_in(clk_in), .en_in(hen), .slow_in(slow), .xfer_req_n_in(req_n),
    .rd_data_in(rdata), .rd_strobe_out(strobe), .rd_addr_out(addr),
    .blk_out(got), .cnt_out(hcnt));

  // ************************************
  // helpers
  // ************************************
  function automatic logic [271:0] rnd272();
    logic [287:0] t;
    for (int i = 0; i < 9; i++) t[i*32 +: 32] = $urandom;
    return t[271:0];
  endfunction

  function automatic logic v_exp(input logic ran, input logic hf, input logic vk);
    case ({oa, vf})
      2'b00: return ran & hf & vk;
      2'b01: return vk;
      2'b10: return ran;
      default: return 1'b1;
    endcase
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic tally_and_finish();
    $display("counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic host_cmp(input logic [271:0] x);
    logic [7:0] n0;
    logic       oe_seen;
    n0 = hcnt;
    oe_seen = 1'b0;
    for (int i = 0; i < 600 && hcnt === n0; i++) begin
      oe_seen |= (flag_oe === 1'b1);
      tick(1);
    end
    chk(got === x, "block read back");
    if (fmode === 1'b0) chk(oe_seen, "flag pin not driven during read");
  endtask

  // strobe already raised by caller; it is dropped after one edge
  task automatic load_chk(input logic e);
    tick(1);
    hd = 1'b0;
    vvalid = 1'b0;
    chk(req_n === 1'b1, "gap before request");
    tick(1);
    chk(req_n === !e, "request level after load");
  endtask

  task automatic fs_pulse();
    fs = 1'b1;
    tick(1);
    fs = 1'b0;
  endtask

  task automatic h_blk(input logic [3:0] s, input logic hold);
    logic e;
    e = oa | (&s);
    last_x = rnd272();
    hdata = last_x;
    {crc, bs, fsy, dp} = s;
    hd = 1'b1;
    load_chk(e);
    fsy = 1'b1;
    if (e && !hold) host_cmp(last_x);
  endtask

  task automatic vslot(input logic [7:0] num, input logic ran);
    logic e;
    block_id_code = 1'b1;
    tick(1);
    block_id_code = 1'b0;
    for (int i = 0; i < 8 && vfetch !== 1'b1; i++) tick(1);
    chk(vfetch === 1'b1 && vnum === num, "vertical fetch slot");
    tick(2'($urandom));
    {vhf, vok} = 2'($urandom);
    e = v_exp(ran, vhf, vok);
    last_x = rnd272();
    vdata = last_x;
    vvalid = 1'b1;
    load_chk(e);
    if (e) host_cmp(last_x);
  endtask

  task automatic frame_run(input logic fail, input int n);
    fs_pulse();
    h_blk({!fail, 3'b111}, 1'b0);
    fs_pulse();
    seen = 1'b0;
    for (int i = 0; i < 4; i++) begin
      seen |= (vstart === 1'b1);
      tick(1);
    end
    chk(seen === fail, "product pass start");
    vdone = fail;
    tick(1);
    vdone = 1'b0;
    // block 1 came with frame start; the slot task sends the bic of block 29
    repeat (27) begin
      block_id_code = 1'b1;
      tick(1);
      block_id_code = 1'b0;
      tick(1);
    end
    for (int k = 1; k <= n; k++) vslot(8'(k), fail);
  endtask

  // ************************************
  // clock, timeout, main sequence
  // ************************************
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    {oa, fmode, vf, fs, block_id_code, hd, vdone, vvalid, vhf, vok} = '0;
    {crc, bs, fsy, dp, hen} = 5'h1F;
    hdata = '0;
    vdata = '0;
    slow = 4'h0;
    rst_in = 1'b1;
    tick(12);
    chk(req_n === 1'b1 && flag_oe === 1'b0 && vfetch === 1'b0, "reset state");
    rst_in = 1'b0;
    void'($urandom(32'hCA9DA6BA));
    tick(2);
    // one condition missing at a time, then random, output-all later
    fs_pulse();
    for (int i = 0; i < 20; i++) begin
      oa = (i >= 10) ? 1'($urandom) : 1'b0;
      slow = 4'($urandom);
      st = (i < 4) ? ~(4'h1 << i) : ((i == 4) ? 4'hF : 4'($urandom));
      chk(flag_oe === 1'b0, "flag released when idle");
      h_blk(st, 1'b0);
    end
    $display("test horizontal done");
    // unread block expires; flag leads the expiry by the margin
    oa = 1'b0;
    fmode = 1'b1;
    hen = 1'b0;
    fs_pulse();
    h_blk(4'hF, 1'b1);
    chk(flag === 1'b0 && flag_oe === 1'b1, "flag low with request");
    r = 0;
    f = 0;
    while (r < 2 * HO_C && req_n === 1'b0) begin
      if (flag === 1'b0) f++;
      r++;
      tick(1);
    end
    chk(r >= HO_C - 2 && r <= HO_C + 2, "window length");
    chk(r - f >= MG_C - 1, "flag margin before expiry");
    // newest block overwrites an unread one
    h_blk(4'hF, 1'b1);
    h_blk(4'hF, 1'b1);
    hen = 1'b1;
    host_cmp(last_x);
    fmode = 1'b0;
    $display("test window done");
    for (int m = 0; m < 8; m++) begin
      {oa, vf} = 2'(m >> 1);
      frame_run(m[0], 4);
    end
    $display("test modes done");
    {oa, vf} = 2'b00;
    frame_run(1'b0, 190);
    block_id_code = 1'b1;
    tick(1);
    block_id_code = 1'b0;
    seen = 1'b0;
    for (int i = 0; i < 6; i++) begin
      seen |= (vfetch === 1'b1);
      tick(1);
    end
    chk(seen === 1'b0, "no slot after last");
    $display("test slot range done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
